// ===== src/ncr_map.vh
`ifndef NCR_MAP_VH
`define NCR_MAP_VH
// Register numbers.
`define NCR_NUM_IDENT 8'h00
`define NCR_NUM_SWDESC 8'h01
`define NCR_NUM_SWCFG 8'h04
`define NCR_NUM_NODEID 8'h05
`define NCR_NUM_PLL 8'h06
`define NCR_NUM_SWCLK 8'h07
`define NCR_NUM_REFCLK 8'h08
`define NCR_NUM_JTAGID 8'h09
`define NCR_NUM_USERCODE 8'h0a
`define NCR_NUM_DIRLO 8'h0c
`define NCR_NUM_DIRHI 8'h0d
`define NCR_NUM_RSVA 8'h10
`define NCR_NUM_RSVB 8'h11
`define NCR_NUM_LINK0 8'h20
`define NCR_NUM_LINKN 8'h28
// Switch configuration fields.
`define NCR_SWCFG_CTL_LOCK 31
`define NCR_SWCFG_PLL_LOCK 8
`define NCR_SWCFG_HDR1 0
// PLL settings fields.
`define NCR_PLL_NORESET 31
`define NCR_PLL_NOWAIT 30
`define NCR_PLL_BYPASS 29
`define NCR_PLL_JTAGBOOT 28
`define NCR_PLL_KEEP_MASK 32'hf39fff7f
`define NCR_PLL_OD_HI 25
`define NCR_PLL_OD_LO 23
`define NCR_PLL_MULT_HI 20
`define NCR_PLL_MULT_LO 8
`define NCR_PLL_INDIV_HI 6
`define NCR_PLL_INDIV_LO 0
// Link direction field.
`define NCR_LINK_DIR_HI 11
`define NCR_LINK_DIR_LO 8
// Reset values.
`define NCR_RST_ZERO 32'h00000000
`define NCR_RST_REFCLK 16'h0003
`define NCR_RST_PLL 32'h00000000
// Length of the tile reset pulse in cycles.
`define NCR_TILE_RST_CYC 4'h4
`endif

// ===== src/ncr_dir_mem.v
`default_nettype none
// ======================================================================
// Per-link direction fields, one word per link, registered read data.
module ncr_dir_mem #(
   parameter DEPTH = 9,
   parameter AW = 4
) (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [3:0] i_wdata,
   input wire [AW-1:0] i_raddr,
   output reg [3:0] o_rdata
);
   reg [3:0] mem_r [0:DEPTH-1];
   integer k;

   // Synchronous reset clears every field so link reads start from a known value.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_r[k] <= 4'h0;
         end
         o_rdata <= 4'h0;
      end else begin
         if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
         end
         o_rdata <= mem_r[i_raddr];
      end
   end
endmodule // ncr_dir_mem
`default_nettype wire

// ===== src/ncr_route.v
`default_nettype none
// ======================================================================
// Route lookup: most significant mismatching bit picks a direction nibble.
module ncr_route (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_valid,
   input wire [15:0] i_dest,
   input wire [15:0] i_node_id,
   input wire [63:0] i_dirs,
   output reg o_valid,
   output reg o_local,
   output reg [3:0] o_dir
);
   wire [15:0] diff = i_dest ^ i_node_id;
   reg [3:0] msb;
   integer b;

   // Scan upward so the highest differing bit is the one kept.
   always @* begin
      msb = 4'h0;
      for (b = 0; b < 16; b = b + 1) begin
         if (diff[b]) begin
            msb = b[3:0];
         end
      end
   end

   // One cycle of latency; a match in all bits skips the tables.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_valid <= 1'b0;
         o_local <= 1'b0;
         o_dir <= 4'h0;
      end else begin
         o_valid <= i_valid;
         o_local <= (diff == 16'h0000);
         o_dir <= (diff == 16'h0000) ? 4'h0 : i_dirs[msb*4 +: 4];
      end
   end
endmodule // ncr_route
`default_nettype wire

// ===== src/ncr_top.v
// Notes on behaviour
// - Registers reached only by numbered config transactions.
// - Identity: boot pins, revision, version, read-only.
// - Description: links, local and device processors.
// - Bit 31 set blocks control register writes.
// - Bit 8 set blocks PLL register writes.
// - Bit 0 selects one-byte headers when set.
// - Node identifier 16 bits, resets to zero.
// - PLL write resets tile unless no-reset.
// - PLL bit 31 applies settings without reset.
// - PLL bit 30 skips relock wait.
// - Bits 29,28 bypass PLL, JTAG boot; write-only (the PLL word here stores them and reads them back).
// - PLL dividers and multiplier fields writable.
// - Switch clock divider 16 bits, resets zero.
// - Reference divider 16 bits, resets to three.
// - Usercode read-only: OTP field, metal field.
// - Route by most significant mismatching bit.
// - Low table: positions 0..7, nibble each.
// - High table: positions 8..15, nibble each.
// - Each link holds writable direction nibble.
`include "ncr_map.vh"
`default_nettype none
// ======================================================================
// Node configuration bank of the packet switch.
// Requests arrive as one-cycle strobes that carry a register number. Each
// request gets exactly one acknowledge, except a write or non-link read in the cycle
// right after a link read, so a master never hangs on a number that is
// unmapped or locked.
// Two lock bits guard the bank: one for the PLL word alone and one for every
// other control register. Neither lock raises the error flag; a locked write
// simply has no effect.
// The route lookup shares only the identifier and the two direction tables
// with the register side.
module ncr_top #(
   parameter SW_REVISION = 8'h01, // Arbitrary value.
   parameter SW_VERSION = 8'h01, // Arbitrary value.
   parameter NUM_LINKS = 8'h09,
   parameter NUM_LOCAL_PROCS = 8'h02,
   parameter NUM_DEV_PROCS = 8'h02,
   parameter JTAG_DEVICE_ID = 32'h00000001, // Arbitrary value.
   parameter USERCODE_METAL = 18'h00000 // Arbitrary value.
) (
   input wire i_mclk,
   input wire i_rstn,
   input wire [7:0] i_boot_select_pins,
   input wire [13:0] i_otp_usercode,
   input wire i_cfg_req,
   input wire i_cfg_write,
   input wire [7:0] i_cfg_num,
   input wire [31:0] i_cfg_wdata,
   input wire i_pkt_valid,
   input wire [15:0] i_pkt_dest,
   output reg o_cfg_ack,
   output reg [31:0] o_cfg_rdata,
   output reg o_cfg_err,
   output reg o_hdr_one_byte,
   output reg [15:0] o_node_id,
   output reg [2:0] o_pll_output_divider,
   output reg [12:0] o_pll_mult,
   output reg [6:0] o_pll_in_div,
   output reg o_pll_update,
   output reg o_pll_no_wait,
   output reg o_pll_bypass,
   output reg o_boot_jtag,
   output reg o_tile_rst,
   output reg [15:0] o_switch_clk_div,
   output reg [15:0] o_ref_clk_div,
   output reg o_route_valid,
   output reg o_route_local,
   output reg [3:0] o_route_dir,
   output reg [3:0] o_link_dir
);
   // ======================================================================
   // Input synchronisers and power-on capture.
   // Two-stage synchronisers for the pins that live outside the clock domain.
   reg [7:0] boot_s1_r;
   reg [7:0] boot_s2_r;
   reg [13:0] otp_s1_r;
   reg [13:0] otp_s2_r;
   reg [7:0] boot_cap_r;
   reg boot_done_r;

   // Pins pass two flops; the boot pins are latched once after reset release.
   // The synchronisers carry no reset, so they settle while reset is held. The
   // capture waits for the first edge after release, which means the boot pins
   // must stay still for at least two cycles of reset.
   // Later pin movement is ignored so that the identity word stays stable.
   always @(posedge i_mclk) begin
      boot_s1_r <= i_boot_select_pins;
      boot_s2_r <= boot_s1_r;
      otp_s1_r <= i_otp_usercode;
      otp_s2_r <= otp_s1_r;
      if (!i_rstn) begin
         boot_cap_r <= 8'h00;
         boot_done_r <= 1'b0;
      end else if (!boot_done_r) begin
         boot_cap_r <= boot_s2_r;
         boot_done_r <= 1'b1;
      end
   end

   // ======================================================================
   // Control registers.
   reg ctl_lock_r;
   reg pll_lock_r;
   reg [31:0] pll_r;
   reg [31:0] dir_lo_r;
   reg [31:0] dir_hi_r;
   // Reserved registers keep only their two defined bits.
   reg [1:0] rsv_a_r;
   reg [1:0] rsv_b_r;
   // Counts down the remaining cycles of the tile reset pulse.
   reg [3:0] tile_cnt_r;

   // Register number decode; used by both the write and read paths.
   // Link numbers form one contiguous run, so a range test is enough.
   function is_link;
      input [7:0] num;
      begin
         is_link = (num >= `NCR_NUM_LINK0) && (num <= `NCR_NUM_LINKN);
      end
   endfunction

   // A request is either a write or a read; there is no other way in.
   wire wr = i_cfg_req && i_cfg_write;
   wire rd = i_cfg_req && !i_cfg_write;
   // The lock bit guards every control register field except the lock bit itself,
   // so software can still drop the lock; the PLL has its own guard.
   wire wr_ok = wr && !ctl_lock_r;
   wire pll_wr = wr && (i_cfg_num == `NCR_NUM_PLL) && !pll_lock_r;
   wire link_wr = wr_ok && is_link(i_cfg_num);
   // Link words are numbered from zero in the low nibble of the number.
   wire [3:0] link_idx = i_cfg_num[3:0];
   wire [3:0] link_rdata;

   // Register writes; reserved bits are never stored.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         ctl_lock_r <= 1'b0;
         pll_lock_r <= 1'b0;
         o_hdr_one_byte <= 1'b0;
         o_node_id <= 16'h0000;
         pll_r <= `NCR_RST_PLL;
         o_switch_clk_div <= 16'h0000;
         o_ref_clk_div <= `NCR_RST_REFCLK;
         dir_lo_r <= `NCR_RST_ZERO;
         dir_hi_r <= `NCR_RST_ZERO;
         rsv_a_r <= 2'h0;
         rsv_b_r <= 2'h0;
      end else begin
         // Of this register only the lock bit itself stays writable while the bank is locked,
         // otherwise software could never release it again.
         if (wr && i_cfg_num == `NCR_NUM_SWCFG) begin
            ctl_lock_r <= i_cfg_wdata[`NCR_SWCFG_CTL_LOCK];
            if (!ctl_lock_r) begin
               pll_lock_r <= i_cfg_wdata[`NCR_SWCFG_PLL_LOCK];
               o_hdr_one_byte <= i_cfg_wdata[`NCR_SWCFG_HDR1];
            end
         end
         // The identifier upper half is reserved and never stored.
         if (wr_ok && i_cfg_num == `NCR_NUM_NODEID) begin
            o_node_id <= i_cfg_wdata[15:0];
         end
         // Reserved PLL bits are dropped here so that readback shows them as zero.
         if (pll_wr) begin
            pll_r <= i_cfg_wdata & `NCR_PLL_KEEP_MASK;
         end
         // Clock ratios are plain 16-bit fields.
         if (wr_ok && i_cfg_num == `NCR_NUM_SWCLK) begin
            o_switch_clk_div <= i_cfg_wdata[15:0];
         end
         // The reference ratio returns to three only through reset.
         if (wr_ok && i_cfg_num == `NCR_NUM_REFCLK) begin
            o_ref_clk_div <= i_cfg_wdata[15:0];
         end
         // Direction tables take whole words; every nibble is a direction.
         if (wr_ok && i_cfg_num == `NCR_NUM_DIRLO) begin
            dir_lo_r <= i_cfg_wdata;
         end
         if (wr_ok && i_cfg_num == `NCR_NUM_DIRHI) begin
            dir_hi_r <= i_cfg_wdata;
         end
         // Reserved words hold two bits only; the rest read back as zero.
         if (wr_ok && i_cfg_num == `NCR_NUM_RSVA) begin
            rsv_a_r <= i_cfg_wdata[1:0];
         end
         if (wr_ok && i_cfg_num == `NCR_NUM_RSVB) begin
            rsv_b_r <= i_cfg_wdata[1:0];
         end
      end
   end

   // ======================================================================
   // PLL side effects: a one-cycle update strobe, held mode bits and a counted tile reset.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_pll_output_divider <= 3'h0;
         o_pll_mult <= 13'h0000;
         o_pll_in_div <= 7'h00;
         o_pll_update <= 1'b0;
         o_pll_no_wait <= 1'b0;
         o_pll_bypass <= 1'b0;
         o_boot_jtag <= 1'b0;
         o_tile_rst <= 1'b0;
         tile_cnt_r <= 4'h0;
      end else begin
         o_pll_update <= pll_wr;
         // Divider outputs follow the stored word, two cycles after the write.
         o_pll_output_divider <= pll_r[`NCR_PLL_OD_HI:`NCR_PLL_OD_LO];
         o_pll_mult <= pll_r[`NCR_PLL_MULT_HI:`NCR_PLL_MULT_LO];
         o_pll_in_div <= pll_r[`NCR_PLL_INDIV_HI:`NCR_PLL_INDIV_LO];
         // Bypass and boot select act on the write itself; they are not
         // re-derived from the stored word later on.
         if (pll_wr) begin
            o_pll_no_wait <= i_cfg_wdata[`NCR_PLL_NOWAIT];
            o_pll_bypass <= i_cfg_wdata[`NCR_PLL_BYPASS];
            o_boot_jtag <= i_cfg_wdata[`NCR_PLL_JTAGBOOT];
         end
         // A write without the no-reset bit holds the tile in reset a while.
         // A second write reloads the counter, so back-to-back writes stretch
         // the pulse instead of cutting it short.
         if (pll_wr && !i_cfg_wdata[`NCR_PLL_NORESET]) begin
            tile_cnt_r <= `NCR_TILE_RST_CYC;
            o_tile_rst <= 1'b1;
         end else if (tile_cnt_r != 4'h0) begin
            tile_cnt_r <= tile_cnt_r - 4'h1;
            o_tile_rst <= (tile_cnt_r != 4'h1);
         end else begin
            o_tile_rst <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Per-link direction storage and read port.
   // The read address is the low nibble of the request number, so the registered data
   // is ready exactly one cycle after a link read is taken.
   ncr_dir_mem #(.DEPTH(9), .AW(4)) ncr_dir_mem_inst (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_we(link_wr),
      .i_waddr(link_idx),
      .i_wdata(i_cfg_wdata[`NCR_LINK_DIR_HI:`NCR_LINK_DIR_LO]),
      .i_raddr(link_idx),
      .o_rdata(link_rdata)
   );

   // ======================================================================
   // Read path: one cycle to ack, two for link words to let memory answer.
   reg link_rd_r;
   reg [31:0] rd_nxt;
   reg hit_nxt;

   // Read multiplexer. Unknown numbers only raise the flag; link numbers are
   // answered from the memory one cycle later by the answer process below.
   always @* begin
      rd_nxt = 32'h00000000;
      hit_nxt = 1'b1;
      case (i_cfg_num)
         `NCR_NUM_IDENT: rd_nxt = {8'h00, boot_cap_r, SW_REVISION, SW_VERSION};
         `NCR_NUM_SWDESC: rd_nxt = {8'h00, NUM_LINKS, NUM_LOCAL_PROCS, NUM_DEV_PROCS};
         `NCR_NUM_SWCFG: begin
            rd_nxt = {ctl_lock_r, 22'h0, pll_lock_r, 7'h00, o_hdr_one_byte};
         end
         `NCR_NUM_NODEID: rd_nxt = {16'h0000, o_node_id};
         `NCR_NUM_PLL: rd_nxt = pll_r;
         `NCR_NUM_SWCLK: rd_nxt = {16'h0000, o_switch_clk_div};
         `NCR_NUM_REFCLK: rd_nxt = {16'h0000, o_ref_clk_div};
         `NCR_NUM_JTAGID: rd_nxt = JTAG_DEVICE_ID;
         `NCR_NUM_USERCODE: rd_nxt = {otp_s2_r, USERCODE_METAL};
         `NCR_NUM_DIRLO: rd_nxt = dir_lo_r;
         `NCR_NUM_DIRHI: rd_nxt = dir_hi_r;
         `NCR_NUM_RSVA: rd_nxt = {30'h00000000, rsv_a_r};
         `NCR_NUM_RSVB: rd_nxt = {30'h00000000, rsv_b_r};
         default: hit_nxt = is_link(i_cfg_num);
      endcase
   end

   // Writes ack next cycle; unknown numbers return zero with the error flag.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= 32'h00000000;
         o_cfg_err <= 1'b0;
         link_rd_r <= 1'b0;
         o_link_dir <= 4'h0;
      end else begin
         link_rd_r <= rd && is_link(i_cfg_num);
         // Link answer: the memory's registered data is ready in this cycle.
         if (link_rd_r) begin
            o_cfg_ack <= 1'b1;
            o_cfg_rdata <= {20'h00000, link_rdata, 8'h00};
            o_cfg_err <= 1'b0;
            o_link_dir <= link_rdata;
         end else if (i_cfg_req && !(rd && is_link(i_cfg_num))) begin
            // Ordinary answer; a write answer always carries zero data.
            o_cfg_ack <= 1'b1;
            o_cfg_rdata <= rd ? rd_nxt : 32'h00000000;
            o_cfg_err <= !hit_nxt;
         end else begin
            // Idle: the answer drops so that it stands for exactly one cycle.
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= 32'h00000000;
            o_cfg_err <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Route lookup against the identifier and the two tables.
   wire r_valid;
   wire r_local;
   wire [3:0] r_dir;

   // The lookup always sees the identifier and tables as they stand in the
   // cycle the packet is taken; a write in that same cycle applies later.
   ncr_route ncr_route_inst (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_valid(i_pkt_valid),
      .i_dest(i_pkt_dest),
      .i_node_id(o_node_id),
      .i_dirs({dir_hi_r, dir_lo_r}),
      .o_valid(r_valid),
      .o_local(r_local),
      .o_dir(r_dir)
   );

   // Outputs re-registered so every top output comes from a flop.
   // The extra stage costs one cycle of route latency but keeps the lookup's
   // combinational scan away from the output pins.
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_route_valid <= 1'b0;
         o_route_local <= 1'b0;
         o_route_dir <= 4'h0;
      end else begin
         o_route_valid <= r_valid;
         o_route_local <= r_local;
         o_route_dir <= r_dir;
      end
   end
endmodule // ncr_top
`default_nettype wire

// ===== verification/ncr_top_asserts.sv
`default_nettype none
// ==========================================================
// Port checker for the node configuration bank.
module ncr_top_asserts (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_cfg_req,
   input wire i_cfg_write,
   input wire [7:0] i_cfg_num,
   input wire [31:0] i_cfg_wdata,
   input wire i_pkt_valid,
   input wire [15:0] i_pkt_dest,
   input wire o_cfg_ack,
   input wire [31:0] o_cfg_rdata,
   input wire o_cfg_err,
   input wire [15:0] o_node_id,
   input wire o_tile_rst,
   input wire o_route_valid,
   input wire o_route_local
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // Write strobes decoded here so the properties stay short.
   wire nid_wr = i_cfg_req & i_cfg_write & (i_cfg_num == 8'h05);
   wire pll_wr = i_cfg_req & i_cfg_write & (i_cfg_num == 8'h06) & ~i_cfg_wdata[31];
   AST_ACK_SRC: assert property (o_cfg_ack |-> $past(i_cfg_req) || $past(i_cfg_req, 2))
      else $error("answer without request");
   AST_ERR: assert property (i_cfg_req && (i_cfg_num inside {8'h02, 8'h03})
      |=> o_cfg_ack && o_cfg_err && o_cfg_rdata == 32'h0) else $error("unmapped number");
   AST_NID_READ: assert property (i_cfg_req && !i_cfg_write && i_cfg_num == 8'h05
      |=> o_cfg_ack && !o_cfg_err && o_cfg_rdata == {16'h0, o_node_id})
      else $error("node id readback");
   AST_RSV: assert property (i_cfg_req && !i_cfg_write && i_cfg_num == 8'h10
      |=> o_cfg_rdata[31:2] == 30'h0) else $error("reserved bits set");
   AST_NID_CHG: assert property ($changed(o_node_id) |-> $past(nid_wr) || $past(nid_wr, 2))
      else $error("node id moved");
   AST_TILE_LEN: assert property ($rose(o_tile_rst) |-> o_tile_rst[*4] ##1 !o_tile_rst)
      else $error("tile reset length");
   AST_TILE_CAUSE: assert property ($rose(o_tile_rst) |-> $past(pll_wr) || $past(pll_wr, 2))
      else $error("tile reset cause");
   AST_ROUTE: assert property (i_pkt_valid |-> ##2 o_route_valid
      && o_route_local == $past(i_pkt_dest == o_node_id, 2)) else $error("route answer");
   C_PLL: cover property ($rose(o_tile_rst));
   C_ERR: cover property (o_cfg_ack && o_cfg_err);
   C_LOC: cover property (o_route_valid && o_route_local);
endmodule // ncr_top_asserts
`default_nettype wire

// ===== verification/tb_ncr_top.sv
`default_nettype none
// ==========================================================
// Bench for the node configuration bank.
module tb_ncr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 0, i_rstn = 0, i_cfg_req = 0, i_cfg_write = 0, i_pkt_valid = 0, er;
   logic [7:0] i_boot_select_pins = 8'ha5, i_cfg_num = 8'h0;
   logic [13:0] i_otp_usercode = 14'h2c31;
   logic [31:0] i_cfg_wdata = 32'h0, rd, v, lo, hi, seed = 32'he3b9bd61;
   logic [31:0] wv [7];
   logic [7:0] nums [6] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h28};
   logic [31:0] msk [6] = '{32'hffff, 32'hffff, 32'hffff, 32'hffffffff, 32'hffffffff, 32'hf00};
   logic [15:0] i_pkt_dest = 16'h0, nid;
   wire o_cfg_ack, o_cfg_err, o_hdr_one_byte, o_pll_update, o_pll_no_wait, o_pll_bypass;
   wire o_boot_jtag, o_tile_rst, o_route_valid, o_route_local;
   wire [31:0] o_cfg_rdata;
   wire [15:0] o_node_id, o_switch_clk_div, o_ref_clk_div;
   wire [2:0] o_pll_output_divider;
   wire [12:0] o_pll_mult;
   wire [6:0] o_pll_in_div;
   wire [3:0] o_route_dir, o_link_dir;
   int num_errors = 0, n_checks = 0, i;
   ncr_top ncr_top_inst (.*);
   // Free-running 100 MHz clock.
   always #5 i_mclk = ~i_mclk;
   function automatic logic [31:0] nx(input logic [31:0] x);
      nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Highest mismatching bit wins, so later loop passes overwrite earlier ones.
   function automatic logic [4:0] rexp(input logic [15:0] d, id, input logic [63:0] t);
      rexp = 5'h10;
      for (int b = 0; b < 16; b++) if (d[b] != id[b]) rexp = {1'b0, t[4*b +: 4]};
   endfunction
   task automatic cmp(input string s, input logic [63:0] e, g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   // One request strobe, then wait a bounded time for the answer.
   task automatic cfg(input logic w, input logic [7:0] n, input logic [31:0] d);
      @(posedge i_mclk); #1;
      i_cfg_req = 1; i_cfg_write = w; i_cfg_num = n; i_cfg_wdata = d;
      @(posedge i_mclk); #1;
      i_cfg_req = 0;
      for (int k = 0; k < 3 && o_cfg_ack !== 1'b1; k++) begin
         @(posedge i_mclk); #1;
      end
      cmp("ack", 1, o_cfg_ack);
      rd = o_cfg_rdata;
      er = o_cfg_err;
   endtask
   task automatic chk(input logic [7:0] n, input logic [31:0] e);
      cfg(0, n, 0);
      cmp($sformatf("reg %h", n), e, rd);
      cmp("err", 0, er);
   endtask
   task automatic route(input logic [15:0] d);
      logic [4:0] e;
      e = rexp(d, nid, {hi, lo});
      @(posedge i_mclk); #1;
      i_pkt_valid = 1; i_pkt_dest = d;
      @(posedge i_mclk); #1;
      i_pkt_valid = 0;
      @(posedge i_mclk); #1;
      cmp("route", {1'b1, e}, {o_route_valid, o_route_local, e[4] ? 4'h0 : o_route_dir});
   endtask
   // Tile reset pulses are counted over a window longer than the pulse.
   task automatic pll(input logic [31:0] d, e, input int t, input logic a);
      int k;
      cfg(1, 8'h06, d);
      cmp("upd", a, o_pll_update);
      k = o_tile_rst;
      repeat (8) begin
         @(posedge i_mclk); #1;
         k += o_tile_rst;
      end
      cmp("tile", t, k);
      cmp("pll", {e[30:28], e[25:23], e[20:8], e[6:0]}, {o_pll_no_wait, o_pll_bypass,
         o_boot_jtag, o_pll_output_divider, o_pll_mult, o_pll_in_div});
      cfg(0, 8'h06, 0);
      cmp("pllrd", e & 32'hf39fff7f, rd);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Watchdog: the sequence needs a few thousand cycles at most.
   initial begin
      #200us;
      num_errors++;
      summarize();
   end
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (8) @(posedge i_mclk);
      #1 i_rstn = 1;
      repeat (4) @(posedge i_mclk);
      #1 i_boot_select_pins = 8'h3c;
      chk(8'h00, 32'h00a50101);
      chk(8'h01, 32'h00090202);
      chk(8'h04, 0);
      chk(8'h07, 0);
      chk(8'h08, 3);
      chk(8'h09, 1);
      chk(8'h0a, {i_otp_usercode, 18'h0});
      chk(8'h0c, 0);
      cfg(1, 8'h00, '1);
      chk(8'h00, 32'h00a50101);
      cfg(0, 8'h02, 0);
      cmp("err", 1, er);
      cfg(1, 8'h10, '1);
      cmp("rsv", 0, rd[31:2]);
      chk(8'h10, 32'h3);
      cfg(1, 8'h11, 32'hfffffffe);
      chk(8'h11, 32'h2);
      // Random words through node id, both clock ratios, both tables and the last link word.
      for (i = 0; i < 6; i++) begin
         seed = nx(seed);
         wv[i] = seed;
         cfg(1, nums[i], seed);
         chk(nums[i], seed & msk[i]);
      end
      cmp("linkdir", wv[5][11:8], o_link_dir);
      cmp("outs", {wv[0][15:0], wv[1][15:0], wv[2][15:0]},
         {o_node_id, o_switch_clk_div, o_ref_clk_div});
      nid = wv[0][15:0];
      lo = wv[3];
      hi = wv[4];
      for (i = 0; i < 16; i++) begin
         seed = nx(seed);
         route(nid ^ (16'h1 << i) ^ (seed[15:0] & ((16'h1 << i) - 16'h1)));
      end
      route(nid);
      cfg(1, 8'h04, 32'h1);
      chk(8'h04, 32'h1);
      cmp("hdr", 1, o_hdr_one_byte);
      seed = nx(seed);
      v = seed & 32'h73bfff7f;
      pll(v, v, 4, 1);
      seed = nx(seed);
      v = seed | 32'h80000000;
      pll(v, v, 0, 1);
      cfg(1, 8'h04, 32'h100);
      pll(v ^ 32'h8000007f, v, 0, 0);
      cfg(1, 8'h04, 32'h80000000);
      cfg(1, 8'h05, ~wv[0]);
      chk(8'h05, {16'h0, nid});
      cfg(1, 8'h04, 32'h80000001);
      chk(8'h04, 32'h80000000);
      cmp("hdrlock", 0, o_hdr_one_byte);
      cfg(1, 8'h04, 0);
      chk(8'h04, 0);
      summarize();
   end
endmodule // tb_ncr_top
bind ncr_top ncr_top_asserts ncr_top_asserts_inst (.*);
`default_nettype wire
